// File: inc/pe_mux_pkg.sv
// constants and types for the port e function and pad control block
package pe_mux_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL_SINGLE = 3'b000,
        MODE_NORMAL_WIDE = 3'b001,
        MODE_NORMAL_NARROW = 3'b010,
        MODE_SPECIAL_SINGLE = 3'b100,
        MODE_SPECIAL_WIDE = 3'b101,
        MODE_SPECIAL_NARROW = 3'b110,
        MODE_PERIPHERAL = 3'b111
    } mode_t;

    // bus-control signals offered to the port e pins
    typedef struct packed {
        logic e_clock;
        logic data_bus_enable_out;
        logic cal_ref;
        logic clock_test;
        logic queue_status_hi;
        logic queue_status_lo;
        logic low_byte_strobe;
        logic read_write;
    } alt_sig_t;

    // register indexes; byte address is four times the index
    localparam logic [3:0] REG_PORT_E_DATA = 4'h8;
    localparam logic [3:0] REG_PORT_E_DIRECTION = 4'h9;
    localparam logic [3:0] REG_FUNCTION_SELECT = 4'ha;
    localparam logic [3:0] REG_PULLUP_CONTROL = 4'hc;
    localparam logic [3:0] REG_REDUCED_DRIVE = 4'hd;

    // function select fields
    localparam int FS_NO_BUS = 7;
    localparam int FS_CLOCK_TEST = 6;
    localparam int FS_PIPE = 5;
    localparam int FS_NO_E_CLOCK = 4;
    localparam int FS_LOW_STROBE = 3;
    localparam int FS_READ_WRITE = 2;
    localparam int FS_CAL = 1;
    localparam int FS_INV_E = 0;
    localparam logic [7:0] FS_ONCE_MASK = 8'had;
    localparam logic [7:0] FS_RST_NORMAL_EXP = 8'h00;
    localparam logic [7:0] FS_RST_SPECIAL = 8'h2c;
    localparam logic [7:0] FS_RST_PERIPHERAL = 8'hd0;
    localparam logic [7:0] FS_RST_NORMAL_SINGLE = 8'h90;

    // pull-up and reduced-drive fields
    localparam int PU_H = 6;
    localparam int PU_G = 5;
    localparam int PU_E = 4;
    localparam int PU_B = 1;
    localparam int PU_A = 0;
    localparam logic [7:0] PU_MASK = 8'h73;
    localparam logic [7:0] PU_RST = 8'h00;
    localparam int RD_H = 6;
    localparam int RD_G = 5;
    localparam int RD_E = 3;
    localparam int RD_B = 1;
    localparam int RD_A = 0;
    localparam logic [7:0] RD_MASK = 8'h6b;
    localparam logic [7:0] RD_RST = 8'h00;

    // port e pin groups
    localparam logic [7:0] PE_PULL_PINS = 8'h8f;
    localparam logic [1:0] PE_IRQ_UNDRIVEN = 2'h3;
    localparam logic [7:0] PE_STROBE_PIN = 8'h08;
    localparam logic [7:0] PE_ZERO = 8'h00;
endpackage : pe_mux_pkg

// File: core/port_e_function_and_pad_control.sv
// port e pin function mux, pull-up and reduced-drive control
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - pins 1 and 0 never drive, whatever their direction bits say.
// - reads of pins 1 and 0 return the pin level.
// - direction register unmapped in peripheral, or expanded with emulation.
// - a selected alternate function overrides the pin's direction bit.
// - function select resets to a value chosen by the operating mode.
// - peripheral mode hides function select; clock test resets set.
// - pin 7 is bus enable/inverted e in expanded with no-bus clear, else calibration or io.
// - once-bits write once in normal, skip first write in special.
// - clock test never writable in normal; pipe output wins over it.
// - pipe output puts queue status on pins 6 and 5 in expanded.
// - no-e-clock: once normal single, any special single, else never.
// - pin 4 carries e clock, input in peripheral, needs stretch clear in single chip.
// - low strobe on pin 3 except single chip and normal narrow.
// - normal narrow mode drives pin 3 high once reset is released.
// - read/write enable puts bus direction on pin 2 outside single.
// - calibration enable always writable, drives pin 7 when no bus.
// - inverted-e select picks bus enable or inverted e clock.
// - pull-up enables for ports h, g, b, a and port e pins.
// - pull-ups act on inputs only; register absent in peripheral.
// - reduced drive bits per port, reset zero, absent in peripheral.
// - emulation in expanded modes removes port e data and direction from the map.
module port_e_function_and_pad_control
    import pe_mux_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [5:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // mode and bus-control sources
    input wire mode_t i_mode,
    input wire logic i_emulate_port_e_bit,
    input wire logic i_e_stretch_bit,
    input wire alt_sig_t i_alt,
    // port e pins
    input wire logic [7:0] i_pe_in,
    output logic [7:0] o_pe_out,
    output logic [7:0] o_pe_oe_b,
    output logic [7:0] o_pe_pullup,
    output logic o_low_byte_tag_input,
    output logic o_e_clock_from_pin,
    // pad controls for other ports, plus port e reduced drive
    output logic o_pullup_port_h,
    output logic o_pullup_port_g,
    output logic o_pullup_port_b,
    output logic o_pullup_port_a,
    output logic o_weak_drive_port_h,
    output logic o_weak_drive_port_g,
    output logic o_weak_drive_port_e,
    output logic o_weak_drive_port_b,
    output logic o_weak_drive_port_a
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] fs_reset_value(input mode_t m);
        case (m)
            MODE_NORMAL_WIDE, MODE_NORMAL_NARROW: fs_reset_value =
                FS_RST_NORMAL_EXP;
            MODE_PERIPHERAL: fs_reset_value = FS_RST_PERIPHERAL;
            MODE_NORMAL_SINGLE: fs_reset_value = FS_RST_NORMAL_SINGLE;
            default: fs_reset_value = FS_RST_SPECIAL;
        endcase
    endfunction : fs_reset_value

    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    mode_t mode_q;
    logic loaded_q;
    logic [7:0] fs_q;
    logic [7:0] fs_wmask;
    logic fs_written_q;
    logic rd_written_q;
    logic [7:0] data_q;
    logic [7:0] dir_q;
    logic [7:0] pu_q;
    logic [7:0] rd_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] out_d;
    logic [7:0] oe_b_d;
    logic [31:0] rdat_d;
    logic special;
    logic single;
    logic periph;
    logic expanded;
    logic normal_narrow;
    logic port_map;
    logic req;
    logic wr;
    logic [3:0] idx;

    assign o_wb_ack = ack_q;
    assign o_wb_dat = dat_q;

    ////////////////////////////////////////////////////////////////////////
    // pins come from outside the clock domain
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta_q <= PE_ZERO;
            pin_sync_q <= PE_ZERO;
        end else if (i_ce) begin
            pin_meta_q <= i_pe_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // mode decode from the mode captured after reset
    assign special = mode_q[2];
    assign single = (mode_q == MODE_NORMAL_SINGLE) ||
        (mode_q == MODE_SPECIAL_SINGLE);
    assign periph = (mode_q == MODE_PERIPHERAL);
    assign expanded = !single && !periph;
    assign normal_narrow = (mode_q == MODE_NORMAL_NARROW);
    assign port_map = !periph && !(expanded && i_emulate_port_e_bit);

    assign idx = i_wb_adr[5:2];
    assign req = i_wb_cyc && i_wb_stb && !ack_q && loaded_q && i_ce;
    assign wr = req && i_wb_we && i_wb_sel[0];

    ////////////////////////////////////////////////////////////////////////
    // mode capture; the strap is read after reset release, never in reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_q <= MODE_NORMAL_SINGLE;
            loaded_q <= 1'b0;
        end else if (i_ce && !loaded_q) begin
            mode_q <= i_mode;
            loaded_q <= 1'b1;
        end
    end

    // per-bit write policy of the function select register
    always_comb begin
        fs_wmask = PE_ZERO;
        fs_wmask[FS_CAL] = 1'b1;
        if (special) begin
            fs_wmask = fs_wmask | (fs_written_q ? FS_ONCE_MASK : PE_ZERO);
            fs_wmask[FS_CLOCK_TEST] = fs_written_q;
        end else begin
            fs_wmask = fs_wmask | (fs_written_q ? PE_ZERO : FS_ONCE_MASK);
        end
        case (mode_q)
            MODE_NORMAL_SINGLE: fs_wmask[FS_NO_E_CLOCK] = !fs_written_q;
            MODE_SPECIAL_SINGLE: fs_wmask[FS_NO_E_CLOCK] = 1'b1;
            default: fs_wmask[FS_NO_E_CLOCK] = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fs_q <= FS_RST_NORMAL_EXP;
        end else if (i_ce && !loaded_q) begin
            fs_q <= fs_reset_value(i_mode);
        end else if (wr && idx == REG_FUNCTION_SELECT && !periph) begin
            fs_q <= (fs_q & ~fs_wmask) | (i_wb_dat[7:0] & fs_wmask);
        end
    end

    // first write is remembered until the next reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fs_written_q <= 1'b0;
            rd_written_q <= 1'b0;
        end else if (wr && !periph) begin
            if (idx == REG_FUNCTION_SELECT) begin
                fs_written_q <= 1'b1;
            end
            if (idx == REG_REDUCED_DRIVE) begin
                rd_written_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general purpose data and direction
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_q <= PE_ZERO;
            dir_q <= PE_ZERO;
        end else if (i_ce && !loaded_q) begin
            // narrow systems need pin 3 high straight out of reset
            if (i_mode == MODE_NORMAL_NARROW) begin
                data_q <= PE_STROBE_PIN;
                dir_q <= PE_STROBE_PIN;
            end
        end else if (wr && port_map) begin
            if (idx == REG_PORT_E_DATA) begin
                data_q <= i_wb_dat[7:0];
            end
            if (idx == REG_PORT_E_DIRECTION) begin
                dir_q <= i_wb_dat[7:0];
            end
        end
    end

    // pull-up and reduced drive
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pu_q <= PU_RST;
            rd_q <= RD_RST;
        end else if (wr && !periph) begin
            if (idx == REG_PULLUP_CONTROL) begin
                pu_q <= i_wb_dat[7:0] & PU_MASK;
            end
            if (idx == REG_REDUCED_DRIVE &&
                (special ? rd_written_q : !rd_written_q)) begin
                rd_q <= i_wb_dat[7:0] & RD_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped locations read zero and ignore writes
    always_comb begin
        rdat_d = '0;
        case (idx)
            REG_PORT_E_DATA: begin
                if (port_map) begin
                    // undriven pins read their level
                    rdat_d[7:0] = (data_q & ~o_pe_oe_b) |
                        (pin_sync_q & o_pe_oe_b);
                end
            end
            REG_PORT_E_DIRECTION: begin
                if (port_map) begin
                    rdat_d[7:0] = dir_q;
                end
            end
            REG_FUNCTION_SELECT: begin
                if (!periph) begin
                    rdat_d[7:0] = fs_q;
                end
            end
            REG_PULLUP_CONTROL: begin
                if (!periph) begin
                    rdat_d[7:0] = pu_q;
                end
            end
            REG_REDUCED_DRIVE: begin
                if (!periph) begin
                    rdat_d[7:0] = rd_q;
                end
            end
            default: rdat_d = '0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else if (i_ce) begin
            ack_q <= req;
            if (req && !i_wb_we) begin
                dat_q <= rdat_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin function mux; alternate functions override direction bits
    always_comb begin
        out_d = data_q;
        oe_b_d = ~dir_q;
        if (expanded && !fs_q[FS_NO_BUS]) begin
            oe_b_d[7] = 1'b0;
            out_d[7] = fs_q[FS_INV_E] ? !i_alt.e_clock
                : i_alt.data_bus_enable_out;
        end else if (fs_q[FS_CAL]) begin
            oe_b_d[7] = 1'b0;
            out_d[7] = i_alt.cal_ref;
        end
        if (expanded && fs_q[FS_PIPE]) begin
            oe_b_d[6:5] = 2'b00;
            out_d[6] = i_alt.queue_status_hi;
            out_d[5] = i_alt.queue_status_lo;
        end else if (fs_q[FS_CLOCK_TEST] && !single &&
            mode_q != MODE_NORMAL_WIDE && !normal_narrow) begin
            oe_b_d[6] = 1'b0;
            out_d[6] = i_alt.clock_test;
        end
        if (!fs_q[FS_NO_E_CLOCK]) begin
            if (periph) begin
                oe_b_d[4] = 1'b1;
            end else if (!single || !i_e_stretch_bit) begin
                oe_b_d[4] = 1'b0;
                out_d[4] = i_alt.e_clock;
            end
        end
        if (fs_q[FS_LOW_STROBE] && !single && !normal_narrow) begin
            oe_b_d[3] = 1'b0;
            out_d[3] = i_alt.low_byte_strobe;
        end
        if (fs_q[FS_READ_WRITE] && !single) begin
            oe_b_d[2] = 1'b0;
            out_d[2] = i_alt.read_write;
        end
        oe_b_d[1:0] = PE_IRQ_UNDRIVEN;
    end

    // all pad outputs leave from flip-flops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pe_out <= PE_ZERO;
            o_pe_oe_b <= ~PE_ZERO;
            o_pe_pullup <= PE_ZERO;
            o_low_byte_tag_input <= 1'b1;
            o_e_clock_from_pin <= 1'b0;
            o_pullup_port_h <= 1'b0;
            o_pullup_port_g <= 1'b0;
            o_pullup_port_b <= 1'b0;
            o_pullup_port_a <= 1'b0;
            o_weak_drive_port_h <= 1'b0;
            o_weak_drive_port_g <= 1'b0;
            o_weak_drive_port_e <= 1'b0;
            o_weak_drive_port_b <= 1'b0;
            o_weak_drive_port_a <= 1'b0;
        end else if (i_ce) begin
            o_pe_out <= out_d;
            o_pe_oe_b <= oe_b_d;
            // pull-ups only on undriven pins
            o_pe_pullup <= {8{pu_q[PU_E]}} & oe_b_d & PE_PULL_PINS;
            o_low_byte_tag_input <= pin_sync_q[3];
            o_e_clock_from_pin <= pin_sync_q[4];
            o_pullup_port_h <= pu_q[PU_H];
            o_pullup_port_g <= pu_q[PU_G];
            // ports a and b carry the bus outside single chip
            o_pullup_port_b <= pu_q[PU_B] && single;
            o_pullup_port_a <= pu_q[PU_A] && single;
            o_weak_drive_port_h <= rd_q[RD_H];
            o_weak_drive_port_g <= rd_q[RD_G];
            o_weak_drive_port_e <= rd_q[RD_E];
            o_weak_drive_port_b <= rd_q[RD_B];
            o_weak_drive_port_a <= rd_q[RD_A];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_irq_pins_undriven: assert property (
        o_pe_oe_b[1:0] == 2'b11)
        else $error("interrupt pins driven");
    a_irq_pin_read: assert property (
        (req && !i_wb_we && idx == REG_PORT_E_DATA && port_map)
        |=> o_wb_ack && o_wb_dat[1:0] == $past(pin_sync_q[1:0]))
        else $error("interrupt pin read wrong");
    a_dir_unmapped: assert property (
        (req && !i_wb_we && idx == REG_PORT_E_DIRECTION && !port_map)
        |=> o_wb_ack && o_wb_dat == 32'h0)
        else $error("direction visible while unmapped");
    a_reset_load: assert property (
        (i_rst_b && i_ce && !loaded_q)
        |=> fs_q == fs_reset_value($past(i_mode)))
        else $error("function select reset value wrong");
    a_first_write_skip: assert property (
        (wr && idx == REG_FUNCTION_SELECT && special && !fs_written_q)
        |=> (fs_q | 8'h12) == ($past(fs_q) | 8'h12))
        else $error("first special write not ignored");
    a_pipe_status_out: assert property (
        (i_ce && loaded_q && expanded && fs_q[FS_PIPE])
        |=> !o_pe_oe_b[6] && !o_pe_oe_b[5] &&
            o_pe_out[6] == $past(i_alt.queue_status_hi))
        else $error("pipe status not on pins");
    a_clock_test_out: assert property (
        (i_ce && loaded_q && periph && fs_q[FS_CLOCK_TEST])
        |=> !o_pe_oe_b[6] && o_pe_out[6] == $past(i_alt.clock_test))
        else $error("clock test output missing");
    a_e_clock_input: assert property (
        (i_ce && loaded_q && periph) |=> o_pe_oe_b[4])
        else $error("e clock driven in peripheral mode");
    a_strobe_blocked: assert property (
        (i_ce && loaded_q && (single || normal_narrow) && !dir_q[3])
        |=> o_pe_oe_b[3])
        else $error("strobe driven where it has no effect");
    a_rw_pin_out: assert property (
        (i_ce && loaded_q && !single && fs_q[FS_READ_WRITE])
        |=> !o_pe_oe_b[2] && o_pe_out[2] == $past(i_alt.read_write))
        else $error("read write not on pin 2");
    a_ack_single: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");

endmodule : port_e_function_and_pad_control

// File: bench/pe_pad_model.sv
// pad and far-side model that resolves the port e pin levels
`timescale 1ns/1ns
module pe_pad_model (
    // block side
    input wire logic i_clk,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe_b,
    input wire logic [7:0] i_pull,
    // far side drive
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_val,
    // resolved levels
    output logic [7:0] o_pin
);
    logic [7:0] float_q = 8'h55;

    // undriven lines wander so a stale value never passes
    always @(posedge i_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (!i_oe_b[k]) o_pin[k] = i_out[k];
            else if (i_ext_en[k]) o_pin[k] = i_ext_val[k];
            else if (i_pull[k]) o_pin[k] = 1'b1;
            else o_pin[k] = float_q[k];
        end
    end
endmodule : pe_pad_model

// File: bench/port_e_function_and_pad_control_tb_top.sv
// self-checking bench for the port e function and pad control block
`timescale 1ns/1ns
module port_e_function_and_pad_control_tb_top
    import pe_mux_pkg::*;
    ;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] dat = 32'h0;
    logic ack;
    logic [31:0] rdat;
    mode_t mode = MODE_NORMAL_WIDE;
    logic emu = 1'b0;
    logic ce = 1'b1;
    logic e_stretch_bit = 1'b0;
    alt_sig_t alt = 8'h5a;
    logic [7:0] pin, pe_out, pe_oe_b, pe_pull;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic tag, eclk_in, pu_h, pu_g, pu_b, pu_a;
    logic wd_h, wd_g, wd_e, wd_b, wd_a;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    port_e_function_and_pad_control i_dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat),
        .o_wb_ack(ack), .o_wb_dat(rdat),
        .i_mode(mode), .i_emulate_port_e_bit(emu),
        .i_e_stretch_bit(e_stretch_bit), .i_alt(alt),
        .i_pe_in(pin), .o_pe_out(pe_out), .o_pe_oe_b(pe_oe_b),
        .o_pe_pullup(pe_pull), .o_low_byte_tag_input(tag),
        .o_e_clock_from_pin(eclk_in),
        .o_pullup_port_h(pu_h), .o_pullup_port_g(pu_g),
        .o_pullup_port_b(pu_b), .o_pullup_port_a(pu_a),
        .o_weak_drive_port_h(wd_h), .o_weak_drive_port_g(wd_g),
        .o_weak_drive_port_e(wd_e), .o_weak_drive_port_b(wd_b),
        .o_weak_drive_port_a(wd_a)
    );

    pe_pad_model i_pads (
        .i_clk(clk), .i_out(pe_out), .i_oe_b(pe_oe_b), .i_pull(pe_pull),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; the slave pace is never assumed
    task automatic bus(input logic w, input logic [3:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, d};
        // only the global cycle ceiling ends a wait for ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, e);
    endtask : rdc

    task automatic rst(input mode_t m);
        @(posedge clk);
        rst_b <= 1'b0;
        mode <= m;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : rst

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        mode_t ml[7] = '{MODE_NORMAL_SINGLE, MODE_NORMAL_WIDE,
            MODE_NORMAL_NARROW, MODE_SPECIAL_SINGLE, MODE_SPECIAL_WIDE,
            MODE_SPECIAL_NARROW, MODE_PERIPHERAL};
        logic [7:0] ex[7] = '{FS_RST_NORMAL_SINGLE, FS_RST_NORMAL_EXP,
            FS_RST_NORMAL_EXP, FS_RST_SPECIAL, FS_RST_SPECIAL,
            FS_RST_SPECIAL, 8'h00};
        for (int k = 0; k < 7; k++) begin
            rst(ml[k]);
            rdc(REG_FUNCTION_SELECT, ex[k]);
            rdc(REG_REDUCED_DRIVE, RD_RST);
            rdc(REG_PULLUP_CONTROL, PU_RST);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_normal_once();
        rst(MODE_NORMAL_WIDE);
        wr(REG_FUNCTION_SELECT, 8'hff);
        rdc(REG_FUNCTION_SELECT, 8'haf);
        chk({pe_oe_b[3:2], pe_out[3:2]},
            {2'b00, alt.low_byte_strobe, alt.read_write});
        wr(REG_FUNCTION_SELECT, 8'h00);
        rdc(REG_FUNCTION_SELECT, 8'had);
        wr(REG_REDUCED_DRIVE, 8'hff);
        wr(REG_REDUCED_DRIVE, 8'h00);
        rdc(REG_REDUCED_DRIVE, RD_MASK);
        chk({wd_h, wd_g, wd_e, wd_b, wd_a}, 5'h1f);
        wr(REG_PULLUP_CONTROL, PU_MASK);
        rdc(REG_PULLUP_CONTROL, PU_MASK);
        chk({pu_h, pu_g, pu_b, pu_a}, 4'hc);
        $display("test normal once done");
    endtask : t_normal_once

    task automatic t_special_skip();
        rst(MODE_SPECIAL_WIDE);
        wr(REG_FUNCTION_SELECT, 8'hff);
        rdc(REG_FUNCTION_SELECT, 8'h2e);
        wr(REG_FUNCTION_SELECT, 8'hff);
        rdc(REG_FUNCTION_SELECT, 8'hef);
        $display("test special skip done");
    endtask : t_special_skip

    task automatic t_pins_special();
        alt_sig_t p[2] = '{8'h5a, 8'ha5};
        rst(MODE_SPECIAL_WIDE);
        wr(REG_PORT_E_DIRECTION, 8'hff);
        for (int k = 0; k < 2; k++) begin
            alt <= p[k];
            repeat (4) @(posedge clk);
            chk(pe_out[7:2], {p[k].data_bus_enable_out, p[k].queue_status_hi,
                p[k].queue_status_lo, p[k].e_clock, p[k].low_byte_strobe,
                p[k].read_write});
            chk(pe_oe_b, 8'h03);
        end
        wr(REG_FUNCTION_SELECT, FS_RST_SPECIAL);
        wr(REG_FUNCTION_SELECT, 8'h2d);
        repeat (4) @(posedge clk);
        chk(pe_out[7], !alt.e_clock);
        $display("test special pins done");
    endtask : t_pins_special

    task automatic t_periph();
        rst(MODE_PERIPHERAL);
        wr(REG_PULLUP_CONTROL, PU_MASK);
        rdc(REG_PULLUP_CONTROL, 8'h00);
        wr(REG_FUNCTION_SELECT, 8'h00);
        rdc(REG_FUNCTION_SELECT, 8'h00);
        rdc(REG_PORT_E_DIRECTION, 8'h00);
        ext_en <= 8'h10;
        ext_val <= 8'h10;
        repeat (5) @(posedge clk);
        chk({pe_oe_b[6], pe_out[6]}, {1'b0, alt.clock_test});
        chk({pe_oe_b[4], eclk_in}, 2'b11);
        ext_val <= 8'h00;
        repeat (5) @(posedge clk);
        chk(eclk_in, 1'b0);
        ext_en <= 8'h00;
        $display("test peripheral done");
    endtask : t_periph

    task automatic t_emulate();
        emu <= 1'b1;
        rst(MODE_SPECIAL_WIDE);
        wr(REG_PORT_E_DIRECTION, 8'hff);
        rdc(REG_PORT_E_DIRECTION, 8'h00);
        emu <= 1'b0;
        $display("test emulate done");
    endtask : t_emulate

    task automatic t_narrow();
        alt <= 8'ha5;
        rst(MODE_NORMAL_NARROW);
        chk({pe_oe_b[3], pe_out[3]}, 2'b01);
        wr(REG_FUNCTION_SELECT, 8'h08);
        repeat (4) @(posedge clk);
        chk(pe_out[3], 1'b1);
        $display("test narrow done");
    endtask : t_narrow

    task automatic t_single();
        logic [7:0] q;
        alt <= 8'ha5;
        ext_en <= 8'h0b;
        ext_val <= 8'h02;
        rst(MODE_NORMAL_SINGLE);
        wr(REG_FUNCTION_SELECT, 8'h92);
        wr(REG_FUNCTION_SELECT, 8'h80);
        rdc(REG_FUNCTION_SELECT, 8'h90);
        wr(REG_FUNCTION_SELECT, 8'h82);
        wr(REG_PULLUP_CONTROL, PU_MASK);
        repeat (4) @(posedge clk);
        chk({pe_oe_b[7], pe_out[7]}, {1'b0, alt.cal_ref});
        chk(pe_pull, 8'h0f);
        chk({pu_b, pu_a}, 2'b11);
        bus(1'b0, REG_PORT_E_DATA, 8'h00, q);
        chk(q[1:0], 2'b10);
        chk(tag, 1'b0);
        ext_en <= 8'h00;
        $display("test single chip done");
    endtask : t_single

    task automatic t_stretch();
        rst(MODE_SPECIAL_SINGLE);
        chk(pe_oe_b[7:2], 6'b111011);
        // a low enable must hold every output where it stands
        ce <= 1'b0;
        e_stretch_bit <= 1'b1;
        repeat (4) @(posedge clk);
        chk(pe_oe_b[4], 1'b0);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        chk(pe_oe_b[4], 1'b1);
        e_stretch_bit <= 1'b0;
        $display("test stretch done");
    endtask : t_stretch

    initial begin
        t_reset();
        t_normal_once();
        t_special_skip();
        t_pins_special();
        t_periph();
        t_emulate();
        t_narrow();
        t_single();
        t_stretch();
        final_report();
    end
endmodule : port_e_function_and_pad_control_tb_top
